// ### sim/atp_ext_src.sv
// Purpose: external count clock source
// Assumes: idle low, four cycles per level
// Notes:   clock stands still between bursts
`timescale 1ns/1ps
module atp_ext_src (
  input  wire       clk_i,
  input  wire       start_i,
  input  wire [3:0] num_i,
  output reg        ext_clk_o,
  output reg        done_o
);
  reg [7:0] cnt_q = 8'h00;
  initial ext_clk_o = 1'b0;
  initial done_o = 1'b0;
  // long levels so the 3-ff sampler never misses one
  always @(posedge clk_i)
  begin
    done_o <= cnt_q == 8'h01;
    if (start_i)
      cnt_q <= {1'b0, num_i, 3'b000};
    else if (cnt_q != 8'h00)
    begin
      cnt_q <= cnt_q - 8'h01;
      ext_clk_o <= cnt_q[2] ^ (cnt_q[1:0] == 2'b00);
    end
  end
endmodule // atp_ext_src

// ### sim/atp_timer_properties.sv
// Purpose: port checker for atp_timer
// Assumes: control bytes shadowed from bus writes
// Notes:   bound to every atp_timer
`timescale 1ns/1ps
module atp_timer_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [5:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        main_output_o,
  input wire        inverted_output_o,
  input wire        audio_pwm_out_1_o,
  input wire        audio_pwm_out_2_o
);
  reg  [7:0] c0_q;
  reg  [7:0] c1_q;
  wire       wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  wire       pwm = c1_q[7:6] == 2'b10;
  wire       aud = pwm & c0_q[0];
  wire       frc = pwm & ~c0_q[0] & ~c1_q[5];
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c0_q <= 8'h00;
      c1_q <= 8'h00;
    end
    else if (wr && wb_adr_i[5:2] == 4'h0)
      c0_q <= wb_dat_i[7:0];
    else if (wr && wb_adr_i[5:2] == 4'h1)
      c1_q <= wb_dat_i[7:0];
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_width_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data above bit 7");
  ctrl_gap_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'h0 |-> wb_dat_o[2:1] == 2'b00)
    else $error("unused control bits read nonzero");
  inverse_pair_a: assert property ((!aud)[*3] |-> inverted_output_o == !main_output_o)
    else $error("inverted output not inverse of main");
  audio_idle_a: assert property ((!aud)[*3] |-> !audio_pwm_out_1_o && !audio_pwm_out_2_o)
    else $error("audio outputs active outside audio mode");
  audio_main_a: assert property (aud[*3] |-> !main_output_o && !inverted_output_o)
    else $error("main outputs driven in audio mode");
  pwm_force_a: assert property ((frc && $stable(c1_q))[*3]
    |-> main_output_o == (c1_q[3] ^ c1_q[2] ^ !c1_q[4]))
    else $error("forced pwm level wrong");
  on_level_a: assert property ($rose(c0_q[3]) && c1_q[7:6] == 2'b00
    |-> ##[1:3] main_output_o == (c1_q[3] ^ c1_q[2]))
    else $error("initial level not restored at switch on");
endmodule // atp_timer_chk

bind atp_timer atp_timer_chk u_chk (
  .clk_i             (clk_i),
  .rst_i             (rst_i),
  .wb_cyc_i          (wb_cyc_i),
  .wb_stb_i          (wb_stb_i),
  .wb_we_i           (wb_we_i),
  .wb_adr_i          (wb_adr_i),
  .wb_sel_i          (wb_sel_i),
  .wb_dat_i          (wb_dat_i),
  .wb_dat_o          (wb_dat_o),
  .wb_ack_o          (wb_ack_o),
  .main_output_o     (main_output_o),
  .inverted_output_o (inverted_output_o),
  .audio_pwm_out_1_o (audio_pwm_out_1_o),
  .audio_pwm_out_2_o (audio_pwm_out_2_o)
);

// ### sim/test_atp_timer.sv
// Purpose: self-checking bench for atp_timer
// Assumes: classic wishbone, one request at a time
// Notes:   counting mostly runs off the external source
`timescale 1ns/1ps
module test_atp_timer;
  localparam int SUBD = 3;
  localparam logic [0:5][7:0] DIV = {8'h04, 8'h01, 8'h10, 8'h40, SUBD[7:0], 8'h01};
  localparam logic [0:11][19:0] TBL = {20'h0_FFF9, 20'h0_0000, 20'h1_FFFF, 20'h1_0000,
    20'h2_5500, 20'h3_0300, 20'h4_FFFF, 20'h5_FF03, 20'h6_AAAA, 20'h7_FF03, 20'h8_FFFF, 20'hA_FF00};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        src_go = 1'b0;
  logic [3:0]  src_num = 4'h0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         ext_clk;
  wire         src_done;
  wire         w_main;
  wire         w_inv;
  wire         w_a1;
  wire         w_a2;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_cyc = 0;
  initial forever #20 clk_i = ~clk_i;
  atp_timer #(.SUB_DIV(SUBD)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_clock_input_i(ext_clk), .main_output_o(w_main),
    .inverted_output_o(w_inv), .audio_pwm_out_1_o(w_a1), .audio_pwm_out_2_o(w_a2));
  atp_ext_src u_src (.clk_i(clk_i), .start_i(src_go), .num_i(src_num), .ext_clk_o(ext_clk),
    .done_o(src_done));
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input int exp, input int tol);
    n_tests = n_tests + 1;
    if ((^got === 1'bx) || got + tol < exp || got > exp + tol)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [3:0] idx, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask
  task rd_chk(input logic [3:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(q, e, 0);
  endtask
  task cnt_chk(input int exp, input int tol);
    logic [31:0] lo;
    logic [31:0] hi;
    wb(1'b0, 4'h2, 8'h00, lo);
    wb(1'b0, 4'h3, 8'h00, hi);
    chk({hi[23:0], lo[7:0]}, exp, tol);
  endtask
  task out_chk(input logic [3:0] e);
    chk({28'h000_0000, w_main, w_inv, w_a1, w_a2}, e, 0);
  endtask
  task edges(input logic [3:0] n);
    @(posedge clk_i);
    src_go <= 1'b1;
    src_num <= n;
    @(posedge clk_i);
    src_go <= 1'b0;
    do @(posedge clk_i); while (src_done !== 1'b1);
    repeat (8) @(posedge clk_i);
  endtask
  // timer is always switched off before its modes change
  task cfg(input logic [7:0] c1, input logic [7:0] c0);
    wr(4'h0, 8'h00);
    wr(4'h1, c1);
    wr(4'h0, c0);
    repeat (4) @(posedge clk_i);
  endtask
  always @(posedge clk_i)
  begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 20000)
    begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic lvl;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    out_chk(4'b0100);
    for (int i = 0; i < 10; i++)
      rd_chk(i[3:0], 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      wr(TBL[i][19:16], TBL[i][15:8]);
      rd_chk(TBL[i][19:16], TBL[i][7:0]);
    end
    cfg(8'h00, 8'h68);
    edges(5);
    cnt_chk(5, 0);
    wr(4'h2, 8'h00);
    cnt_chk(5, 0);
    wr(4'h0, 8'hE8);
    edges(3);
    cnt_chk(5, 0);
    wr(4'h0, 8'h68);
    edges(2);
    cnt_chk(7, 0);
    wr(4'h0, 8'h78);
    edges(3);
    cnt_chk(10, 0);
    wr(4'h0, 8'h70);
    edges(2);
    cnt_chk(10, 0);
    wr(4'h0, 8'h78);
    cnt_chk(0, 0);
    wr(4'h8, 8'h01);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    cfg(8'h00, 8'h68);
    edges(6);
    cnt_chk(2, 0);
    rd_chk(4'h9, 8'h02);
    wr(4'h9, 8'h03);
    rd_chk(4'h9, 8'h00);
    // k = {pin function, output control, polarity}, clearing on compare A at 3
    wr(4'h4, 8'h03);
    for (int k = 0; k < 16; k++)
    begin
      cfg({2'b00, k[3:0], 2'b01}, 8'h68);
      out_chk({k[1] ^ k[0], ~(k[1] ^ k[0]), 2'b00});
      edges(3);
      lvl = ((k[3:2] == 2'b00) ? k[1] : (k[3:2] == 2'b11) ? ~k[1] : k[3]) ^ k[0];
      out_chk({lvl, ~lvl, 2'b00});
      rd_chk(4'h9, 8'h01);
    end
    wr(4'h4, 8'h02);
    cfg(8'hA8, 8'h68);
    out_chk(4'b1000);
    edges(2);
    out_chk(4'b0100);
    edges(2);
    out_chk(4'b1000);
    cfg(8'h84, 8'h60);
    out_chk(4'b0100);
    cfg(8'hB8, 8'h60);
    out_chk(4'b0100);
    wr(4'h4, 8'h0C);
    cfg(8'hAA, 8'h68);
    out_chk(4'b1000);
    edges(4);
    out_chk(4'b0100);
    wr(4'h4, 8'h02);
    wr(4'h6, 8'h03);
    wr(4'h7, 8'h00);
    cfg(8'hAA, 8'h69);
    rd_chk(4'h1, 8'hA8);
    out_chk(4'b0011);
    edges(2);
    out_chk(4'b0001);
    edges(1);
    out_chk(4'b0000);
    wr(4'h8, 8'h00);
    wr(4'h4, 8'h00);
    for (int c = 0; c < 6; c++)
    begin
      cfg(8'h00, {1'b0, c[2:0], 4'h8});
      repeat (256) @(posedge clk_i);
      wr(4'h0, {1'b0, c[2:0], 4'h0});
      cnt_chk(262 / DIV[c], 3);
    end
    end_sim();
  end
endmodule // test_atp_timer

// ### verilog/atp_clk_sel.v
// Purpose: counting enable from the selected clock source
// Assumes: high clock equals the system clock
// Notes:   one-cycle enable pulses, no second clock domain
`timescale 1ns/1ps
`include "atp_consts.vh"

module atp_clk_sel #(
  parameter SUB_DIV = 763
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [2:0] sel_i,
  input  wire       ext_clk_i,
  output reg        tick_o
);

  reg  [5:0]  pre_q;
  reg  [12:0] sub_q;
  reg         sync1_q;
  reg         sync2_q;
  reg         sync3_q;
  reg         tick_d;
  wire        sub_end = (sub_q == SUB_DIV - 1);

  ////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_q   <= 6'h00;
      sub_q   <= 13'h0000;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      tick_o  <= 1'b0;
    end
    else
    begin
      pre_q   <= pre_q + 6'h01;
      sub_q   <= sub_end ? 13'h0000 : sub_q + 13'h0001;
      sync1_q <= ext_clk_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      tick_o  <= tick_d;
    end
  end

  // edge taken from the second and third stages only
  always @*
  begin
    case (sel_i)
      `ATP_CK_SYS4:  tick_d = &pre_q[1:0];
      `ATP_CK_SYS:   tick_d = 1'b1;
      `ATP_CK_H16:   tick_d = &pre_q[3:0];
      `ATP_CK_H64:   tick_d = &pre_q[5:0];
      `ATP_CK_SUB:   tick_d = sub_end;
      `ATP_CK_H:     tick_d = 1'b1;
      `ATP_CK_EXT_R: tick_d = sync2_q & ~sync3_q;
      `ATP_CK_EXT_F: tick_d = ~sync2_q & sync3_q;
      default:       tick_d = 1'b0;
    endcase
  end

endmodule // atp_clk_sel

// ### verilog/atp_consts.vh
// Purpose: constants of the audio timer/pwm unit
// Assumes: registers are one 32-bit word each, data in bits 7..0
// Notes:   definitions only
`ifndef ATP_CONSTS_VH
`define ATP_CONSTS_VH

// register word indexes, byte address = 4 * index
`define ATP_IDX_W        4
`define ATP_IDX_CTRL0    4'h0
`define ATP_IDX_CTRL1    4'h1
`define ATP_IDX_CNT_LO   4'h2
`define ATP_IDX_CNT_HI   4'h3
`define ATP_IDX_CMPA_LO  4'h4
`define ATP_IDX_CMPA_HI  4'h5
`define ATP_IDX_CMPB_LO  4'h6
`define ATP_IDX_CMPB_HI  4'h7
`define ATP_IDX_PERIOD   4'h8
`define ATP_IDX_STATUS   4'h9

// control 0 fields
`define ATP_C0_PAUSE     7
`define ATP_C0_CK_HI     6
`define ATP_C0_CK_LO     4
`define ATP_C0_ON        3
`define ATP_C0_SUB       0
// control 1 fields
`define ATP_C1_MODE_HI   7
`define ATP_C1_MODE_LO   6
`define ATP_C1_IO_HI     5
`define ATP_C1_IO_LO     4
`define ATP_C1_OC        3
`define ATP_C1_POL       2
`define ATP_C1_SWAP      1
`define ATP_C1_CCLR      0
// status fields, write one to clear
`define ATP_ST_AF        0
`define ATP_ST_PF        1

`define ATP_RST_BYTE     8'h00
`define ATP_RST_CNT      10'h000

// operating modes
`define ATP_MODE_CMP     2'b00
`define ATP_MODE_PWM     2'b10
`define ATP_MODE_TMR     2'b11
// pin function, compare mode
`define ATP_IO_NONE      2'b00
`define ATP_IO_LOW       2'b01
`define ATP_IO_HIGH      2'b10
`define ATP_IO_TOGGLE    2'b11
// pin function, pwm mode
`define ATP_IO_INACT     2'b00
`define ATP_IO_ACT       2'b01
`define ATP_IO_WAVE      2'b10

// clock select codes
`define ATP_CK_SYS4      3'b000
`define ATP_CK_SYS       3'b001
`define ATP_CK_H16       3'b010
`define ATP_CK_H64       3'b011
`define ATP_CK_SUB       3'b100
`define ATP_CK_H         3'b101
`define ATP_CK_EXT_R     3'b110
`define ATP_CK_EXT_F     3'b111

`endif

// ### verilog/atp_pwm_gen.v
// Purpose: one pwm channel level from counter and duty
// Assumes: counter cleared by the period match
// Notes:   combinational, registered by the caller
`timescale 1ns/1ps
`include "atp_consts.vh"

module atp_pwm_gen #(
  parameter CW = 10
) (
  input  wire [CW-1:0] cnt_i,
  input  wire [CW-1:0] duty_i,
  input  wire [1:0]    io_i,
  input  wire          oc_i,
  input  wire          pol_i,
  output reg           level_o
);

  // duty at or above the period gives a full active level
  wire active = (cnt_i < duty_i);

  always @*
  begin
    case (io_i)
      `ATP_IO_WAVE: level_o = active ? oc_i : ~oc_i;
      `ATP_IO_ACT:  level_o = oc_i;
      default:      level_o = ~oc_i;
    endcase
    level_o = level_o ^ pol_i;
  end

endmodule // atp_pwm_gen

// ### verilog/atp_timer.v
// Purpose: 10-bit audio timer with compare, timer and pwm modes
// Assumes: classic wishbone slave, 32-bit data, 8-bit registers
// Notes:   flags are sticky status bits, no interrupt output
`timescale 1ns/1ps
`include "atp_consts.vh"

module atp_timer #(
  parameter SUB_DIV = 763,
  parameter CW      = 10,
  parameter PW      = 8
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        external_clock_input_i,
  output reg         main_output_o,
  output reg         inverted_output_o,
  output reg         audio_pwm_out_1_o,
  output reg         audio_pwm_out_2_o
);

  ////////////////////////////////////////////////////////////
  // register state

  reg          counter_pause_q;
  reg  [2:0]   clock_select_q;
  reg          timer_on_q;
  reg          pwm_submode_select_q;
  reg  [1:0]   operating_mode_field_q;
  reg  [1:0]   pin_function_field_q;
  reg          output_control_q;
  reg          output_polarity_q;
  reg          period_duty_swap_q;
  reg          counter_clear_select_q;
  reg  [CW-1:0] compare_a_value_q;
  reg  [CW-1:0] compare_b_value_q;
  reg  [PW-1:0] period_value_q;
  reg          compare_a_flag_q;
  reg          compare_p_flag_q;

  reg  [CW-1:0] cnt_q;
  reg          on_prev_q;
  reg          cmp_out_q;

  ////////////////////////////////////////////////////////////
  // bus decode

  wire [`ATP_IDX_W-1:0] idx = wb_adr_i[5:2];
  wire        req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr   = req & wb_we_i & wb_sel_i[0];
  wire [7:0]  wd   = wb_dat_i[7:0];
  wire        wr_c0 = wr & (idx == `ATP_IDX_CTRL0);
  wire        wr_c1 = wr & (idx == `ATP_IDX_CTRL1);
  wire        wr_st = wr & (idx == `ATP_IDX_STATUS);

  ////////////////////////////////////////////////////////////
  // mode decode

  wire mode_cmp = (operating_mode_field_q == `ATP_MODE_CMP);
  wire mode_pwm = (operating_mode_field_q == `ATP_MODE_PWM);
  wire mode_tmr = (operating_mode_field_q == `ATP_MODE_TMR);
  wire audio    = mode_pwm & pwm_submode_select_q;

  ////////////////////////////////////////////////////////////
  // counting enable

  wire tick;

  atp_clk_sel #(
    .SUB_DIV (SUB_DIV)
  ) u_clk_sel (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sel_i     (clock_select_q),
    .ext_clk_i (external_clock_input_i),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////
  // comparators

  wire          on_rise = timer_on_q & ~on_prev_q;
  wire          run     = timer_on_q & ~counter_pause_q;
  wire          step    = run & tick;
  wire [CW-1:0] cnt_inc = cnt_q + {{(CW-1){1'b0}}, 1'b1};
  // period sits on the upper bits, so matches fall on multiples of four;
  // a zero period matches only at the wrap, giving 1024 clocks
  wire [CW-1:0] per_full = {period_value_q, 2'b00};
  wire          hit_p   = step & (cnt_inc == per_full);
  // a zero compare A never matches, the counter just overflows
  wire          hit_a   = step & (cnt_inc == compare_a_value_q) &
                          (compare_a_value_q != {CW{1'b0}});

  reg clr_match;
  reg set_pf;

  always @*
  begin
    if (mode_pwm)
    begin
      // clear select unused in pwm; swap picks which value sets the period
      clr_match = period_duty_swap_q ? hit_a : hit_p;
      set_pf    = hit_p;
    end
    else
    begin
      clr_match = counter_clear_select_q ? hit_a : hit_p;
      set_pf    = hit_p & ~counter_clear_select_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // counter

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q     <= `ATP_RST_CNT;
      on_prev_q <= 1'b0;
    end
    else
    begin
      on_prev_q <= timer_on_q;
      if (on_rise)
        cnt_q <= `ATP_RST_CNT;
      else if (clr_match)
        cnt_q <= `ATP_RST_CNT;
      else if (step)
        cnt_q <= cnt_inc;
    end
  end

  ////////////////////////////////////////////////////////////
  // compare-mode output state

  always @(posedge clk_i)
  begin
    if (rst_i)
      cmp_out_q <= 1'b0;
    else if (on_rise)
      cmp_out_q <= output_control_q;
    else if (mode_cmp & hit_a)
    begin
      // requesting the level already held leaves the pin unchanged
      case (pin_function_field_q)
        `ATP_IO_LOW:    cmp_out_q <= 1'b0;
        `ATP_IO_HIGH:   cmp_out_q <= 1'b1;
        `ATP_IO_TOGGLE: cmp_out_q <= ~cmp_out_q;
        default:        cmp_out_q <= cmp_out_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // pwm channels

  wire [CW-1:0] duty1 = (period_duty_swap_q & ~audio) ?
                        per_full : compare_a_value_q;
  wire          lvl1;
  wire          lvl2;

  atp_pwm_gen #(
    .CW (CW)
  ) u_pwm1 (
    .cnt_i   (cnt_q),
    .duty_i  (duty1),
    .io_i    (pin_function_field_q),
    .oc_i    (output_control_q),
    .pol_i   (output_polarity_q),
    .level_o (lvl1)
  );

  atp_pwm_gen #(
    .CW (CW)
  ) u_pwm2 (
    .cnt_i   (cnt_q),
    .duty_i  (compare_b_value_q),
    .io_i    (pin_function_field_q),
    .oc_i    (output_control_q),
    .pol_i   (output_polarity_q),
    .level_o (lvl2)
  );

  ////////////////////////////////////////////////////////////
  // output pins

  reg main_d;

  always @*
  begin
    if (mode_pwm)
      main_d = lvl1;
    else if (mode_tmr)
      main_d = cmp_out_q;  // pin unused here, level held for safety
    else
      main_d = cmp_out_q ^ output_polarity_q;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      main_output_o     <= 1'b0;
      inverted_output_o <= 1'b1;
      audio_pwm_out_1_o <= 1'b0;
      audio_pwm_out_2_o <= 1'b0;
    end
    else if (audio)
    begin
      main_output_o     <= 1'b0;
      inverted_output_o <= 1'b0;
      audio_pwm_out_1_o <= lvl1;
      audio_pwm_out_2_o <= lvl2;
    end
    else
    begin
      main_output_o     <= main_d;
      inverted_output_o <= ~main_d;
      audio_pwm_out_1_o <= 1'b0;
      audio_pwm_out_2_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // control registers

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      counter_pause_q        <= 1'b0;
      clock_select_q         <= `ATP_CK_SYS4;
      timer_on_q             <= 1'b0;
      pwm_submode_select_q   <= 1'b0;
      operating_mode_field_q <= `ATP_MODE_CMP;
      pin_function_field_q   <= `ATP_IO_NONE;
      output_control_q       <= 1'b0;
      output_polarity_q      <= 1'b0;
      period_duty_swap_q     <= 1'b0;
      counter_clear_select_q <= 1'b0;
    end
    else
    begin
      if (wr_c0)
      begin
        counter_pause_q      <= wd[`ATP_C0_PAUSE];
        clock_select_q       <= wd[`ATP_C0_CK_HI:`ATP_C0_CK_LO];
        timer_on_q           <= wd[`ATP_C0_ON];
        pwm_submode_select_q <= wd[`ATP_C0_SUB];
      end
      if (wr_c1)
      begin
        operating_mode_field_q <= wd[`ATP_C1_MODE_HI:`ATP_C1_MODE_LO];
        pin_function_field_q   <= wd[`ATP_C1_IO_HI:`ATP_C1_IO_LO];
        output_control_q       <= wd[`ATP_C1_OC];
        output_polarity_q      <= wd[`ATP_C1_POL];
        period_duty_swap_q     <= wd[`ATP_C1_SWAP];
        counter_clear_select_q <= wd[`ATP_C1_CCLR];
      end
      // audio mode forces the swap bit low, overriding a write
      if (audio)
        period_duty_swap_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // compare and period registers

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_a_value_q <= {CW{1'b0}};
      compare_b_value_q <= {CW{1'b0}};
      period_value_q    <= `ATP_RST_BYTE;
    end
    else if (wr)
    begin
      case (idx)
        `ATP_IDX_CMPA_LO: compare_a_value_q[7:0]    <= wd;
        `ATP_IDX_CMPA_HI: compare_a_value_q[CW-1:8] <= wd[CW-9:0];
        `ATP_IDX_CMPB_LO: compare_b_value_q[7:0]    <= wd;
        `ATP_IDX_CMPB_HI: compare_b_value_q[CW-1:8] <= wd[CW-9:0];
        `ATP_IDX_PERIOD:  period_value_q            <= wd;
        default:          period_value_q            <= period_value_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // match flags, a new event wins over a clear in the same cycle

  wire clr_af = wr_st & wd[`ATP_ST_AF];
  wire clr_pf = wr_st & wd[`ATP_ST_PF];

  always @(posedge clk_i)
  begin
    if (rst_i | on_rise)
    begin
      compare_a_flag_q <= 1'b0;
      compare_p_flag_q <= 1'b0;
    end
    else
    begin
      if (hit_a)
        compare_a_flag_q <= 1'b1;
      else if (clr_af)
        compare_a_flag_q <= 1'b0;
      if (set_pf)
        compare_p_flag_q <= 1'b1;
      else if (clr_pf)
        compare_p_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // read mux and acknowledge

  reg [7:0] rd;

  always @*
  begin
    rd = `ATP_RST_BYTE;
    case (idx)
      `ATP_IDX_CTRL0:   rd = {counter_pause_q, clock_select_q, timer_on_q,
                              2'b00, pwm_submode_select_q};
      `ATP_IDX_CTRL1:   rd = {operating_mode_field_q, pin_function_field_q,
                              output_control_q, output_polarity_q,
                              period_duty_swap_q, counter_clear_select_q};
      `ATP_IDX_CNT_LO:  rd = cnt_q[7:0];
      `ATP_IDX_CNT_HI:  rd = {6'h00, cnt_q[CW-1:8]};
      `ATP_IDX_CMPA_LO: rd = compare_a_value_q[7:0];
      `ATP_IDX_CMPA_HI: rd = {6'h00, compare_a_value_q[CW-1:8]};
      `ATP_IDX_CMPB_LO: rd = compare_b_value_q[7:0];
      `ATP_IDX_CMPB_HI: rd = {6'h00, compare_b_value_q[CW-1:8]};
      `ATP_IDX_PERIOD:  rd = period_value_q;
      `ATP_IDX_STATUS:  rd = {6'h00, compare_p_flag_q, compare_a_flag_q};
      default:          rd = `ATP_RST_BYTE;
    endcase
  end

  // unmapped words answer with zero and ignore writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req)
        wb_dat_o <= {24'h00_0000, rd};
    end
  end

endmodule // atp_timer
